//--- verilog/lacs_pkg.sv
// Purpose: Shared constants and types for the locomotive address and consist select block.
// Assumes: 8-bit configuration variables at their printed variable numbers.
// Notes:   Ranges bound which writes are accepted.
`default_nettype none
package lacs_pkg;
   // Register port and extended address widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int EXT_W  = 14;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_SHORT   = 8'h01;
   localparam logic [ADDR_W-1:0] OFS_LONG_HI = 8'h11;
   localparam logic [ADDR_W-1:0] OFS_LONG_LO = 8'h12;
   localparam logic [ADDR_W-1:0] OFS_CONSIST = 8'h13;
   localparam logic [ADDR_W-1:0] OFS_RAIL    = 8'h1b;
   localparam logic [ADDR_W-1:0] OFS_CONFIG  = 8'h1d;

   // Reset values
   localparam logic [DATA_W-1:0] RST_SHORT   = 8'h03;
   localparam logic [DATA_W-1:0] RST_LONG_HI = 8'hc0;
   localparam logic [DATA_W-1:0] RST_LONG_LO = 8'h64;
   localparam logic [DATA_W-1:0] RST_CONSIST = 8'h00;
   localparam logic [DATA_W-1:0] RST_RAIL    = 8'h00;
   localparam logic [DATA_W-1:0] RST_CONFIG  = 8'h02;

   // Accepted write ranges
   localparam logic [DATA_W-1:0] SHORT_MIN   = 8'h01;
   localparam logic [DATA_W-1:0] SHORT_MAX   = 8'h7f;
   localparam logic [DATA_W-1:0] LONG_HI_MIN = 8'hc0;
   localparam logic [DATA_W-1:0] LONG_HI_MAX = 8'he7;
   localparam logic [DATA_W-1:0] LONG_LO_MIN = 8'h01;

   // Field positions
   localparam int CFG_LONG_BIT    = 5;
   localparam int CONSIST_DIR_BIT = 7;
   localparam int RAIL_RIGHT_BIT  = 0;
   localparam int RAIL_LEFT_BIT   = 1;
   // Config bits 7 (type) and 3 (back-channel) are fixed at zero
   localparam logic [DATA_W-1:0] CFG_WR_MASK = 8'h77;
   localparam logic [DATA_W-1:0] CONSIST_ADDR_MASK = 8'h7f;

   typedef enum logic [1:0] {LACS_MODE_SHORT, LACS_MODE_LONG, LACS_MODE_CONSIST} lacs_mode_t;
endpackage
`default_nettype wire

//--- verilog/lacs_sel_if.sv
// Purpose: Carries stored addresses to the address selector and its verdict back.
// Assumes: Single clock domain, purely combinational traffic.
// Notes:   cfg side is the register bank, sel side is the selector.
`timescale 1ns/1ps
`default_nettype none
interface lacs_sel_if;
   import lacs_pkg::*;
   logic [DATA_W-1:0] short_addr;
   logic [DATA_W-1:0] long_hi;
   logic [DATA_W-1:0] long_lo;
   logic [DATA_W-1:0] consist;
   logic              long_en;
   lacs_mode_t        mode;
   logic [EXT_W-1:0]  sel_addr;
   logic              dir_invert;

   modport cfg (output short_addr, long_hi, long_lo, consist, long_en,
                input  mode, sel_addr, dir_invert);
   modport sel (input  short_addr, long_hi, long_lo, consist, long_en,
                output mode, sel_addr, dir_invert);
endinterface
`default_nettype wire

//--- verilog/lacs_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs are slow levels.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module lacs_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Levels
   input  wire logic [W-1:0] d_async,
   output logic      [W-1:0] q_sync
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta   <= '0;
         q_sync <= '0;
      end
      else
      begin
         meta   <= d_async;
         q_sync <= meta;
      end
   end
endmodule
`default_nettype wire

//--- verilog/lacs_addr_select.sv
// Purpose: Chooses the address the decoder answers to and the direction sense.
// Assumes: Stored values already range-checked by the register bank.
// Notes:   Consist overrides long, long overrides short.
`timescale 1ns/1ps
`default_nettype none
module lacs_addr_select (
   // Stored addresses in, verdict out
   lacs_sel_if.sel sel
);
   import lacs_pkg::*;

   wire logic [6:0]       consist_addr;
   wire logic             consist_on;
   wire logic [5:0]       hi_offset;
   wire logic [EXT_W-1:0] ext_addr;
   wire logic [DATA_W-1:0] hi_diff;

   assign consist_addr = sel.consist[6:0];
   assign consist_on   = (consist_addr != 7'h00);
   assign hi_diff      = sel.long_hi - LONG_HI_MIN;
   assign hi_offset    = hi_diff[5:0];
   assign ext_addr     = {hi_offset, sel.long_lo};

   assign sel.mode = consist_on  ? LACS_MODE_CONSIST :
                     sel.long_en ? LACS_MODE_LONG : LACS_MODE_SHORT;

   assign sel.sel_addr = consist_on  ? {7'h00, consist_addr} :
                         sel.long_en ? ext_addr :
                                       {6'h00, sel.short_addr};

   assign sel.dir_invert = consist_on & sel.consist[CONSIST_DIR_BIT];
endmodule
`default_nettype wire

//--- verilog/lacs_top.sv
// Purpose: Configuration registers and address selection of a locomotive decoder.
// Assumes: Commands come decoded from same-clock logic; rail sense pins are asynchronous.
// Notes:   Out-of-range writes leave the stored value unchanged.
`timescale 1ns/1ps
`default_nettype none
module lacs_top (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // Register port
   input  wire logic [lacs_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [lacs_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [lacs_pkg::DATA_W-1:0] reg_rdata,
   // Decoded track commands
   input  wire logic                        cmd_valid,
   input  wire logic                        cmd_long_form,
   input  wire logic [lacs_pkg::EXT_W-1:0]  cmd_addr,
   input  wire logic                        cmd_dir,
   // Rail imbalance sense pins
   input  wire logic                        rail_right_asym,
   input  wire logic                        rail_left_asym,
   // Results
   output logic                             cmd_hit,
   output logic                             cmd_dir_eff,
   output logic                             hit_on_consist,
   output logic                             long_active,
   output logic      [lacs_pkg::EXT_W-1:0]  active_addr,
   output logic                             asym_trigger
);
   import lacs_pkg::*;

   // Stored configuration variables
   logic [DATA_W-1:0] short_address_var;
   logic [DATA_W-1:0] long_address_high_byte;
   logic [DATA_W-1:0] long_address_low_byte;
   logic [DATA_W-1:0] consist_address_dir;
   logic [DATA_W-1:0] asym_rail_select;
   logic [DATA_W-1:0] decoder_config_byte;

   lacs_sel_if sel_bus ();

   // Write decode
   wire logic wr_short;
   wire logic wr_hi;
   wire logic wr_lo;
   wire logic wr_consist;
   wire logic wr_rail;
   wire logic wr_config;
   wire logic short_ok;
   wire logic hi_ok;
   wire logic lo_ok;

   assign wr_short   = reg_wr && (reg_addr == OFS_SHORT);
   assign wr_hi      = reg_wr && (reg_addr == OFS_LONG_HI);
   assign wr_lo      = reg_wr && (reg_addr == OFS_LONG_LO);
   assign wr_consist = reg_wr && (reg_addr == OFS_CONSIST);
   assign wr_rail    = reg_wr && (reg_addr == OFS_RAIL);
   assign wr_config  = reg_wr && (reg_addr == OFS_CONFIG);

   assign short_ok = (reg_wdata >= SHORT_MIN) && (reg_wdata <= SHORT_MAX);
   assign hi_ok    = (reg_wdata >= LONG_HI_MIN) && (reg_wdata <= LONG_HI_MAX);
   assign lo_ok    = (reg_wdata >= LONG_LO_MIN);

   // Accepted writes; a refused byte leaves the old value
   wire logic take_short;
   wire logic take_hi;
   wire logic take_lo;

   assign take_short = wr_short && short_ok;
   assign take_hi    = wr_hi && hi_ok;
   assign take_lo    = wr_lo && lo_ok;

   // Fixed-zero config bits dropped on the way in
   wire logic [DATA_W-1:0] config_wdata;

   assign config_wdata = reg_wdata & CFG_WR_MASK;

   // Short address
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         short_address_var <= RST_SHORT;
      end
      else if (take_short)
      begin
         short_address_var <= reg_wdata;
      end
   end

   // Long address, high byte
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         long_address_high_byte <= RST_LONG_HI;
      end
      else if (take_hi)
      begin
         long_address_high_byte <= reg_wdata;
      end
   end

   // Long address, low byte
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         long_address_low_byte <= RST_LONG_LO;
      end
      else if (take_lo)
      begin
         long_address_low_byte <= reg_wdata;
      end
   end

   // Consist address with direction bit
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         consist_address_dir <= RST_CONSIST;
      end
      else if (wr_consist)
      begin
         consist_address_dir <= reg_wdata;
      end
   end

   // Rail select
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         asym_rail_select <= RST_RAIL;
      end
      else if (wr_rail)
      begin
         asym_rail_select <= reg_wdata;
      end
   end

   // Decoder configuration byte
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         decoder_config_byte <= RST_CONFIG;
      end
      else if (wr_config)
      begin
         decoder_config_byte <= config_wdata;
      end
   end

   // Read selects, one per variable
   wire logic rd_short;
   wire logic rd_hi;
   wire logic rd_lo;
   wire logic rd_consist;
   wire logic rd_rail;
   wire logic rd_config;

   assign rd_short   = reg_rd && (reg_addr == OFS_SHORT);
   assign rd_hi      = reg_rd && (reg_addr == OFS_LONG_HI);
   assign rd_lo      = reg_rd && (reg_addr == OFS_LONG_LO);
   assign rd_consist = reg_rd && (reg_addr == OFS_CONSIST);
   assign rd_rail    = reg_rd && (reg_addr == OFS_RAIL);
   assign rd_config  = reg_rd && (reg_addr == OFS_CONFIG);

   // Read mux; idle cycles and unmapped offsets give zero
   wire logic [DATA_W-1:0] next_reg_rdata;

   assign next_reg_rdata = ({DATA_W{rd_short}}   & short_address_var)
                         | ({DATA_W{rd_hi}}      & long_address_high_byte)
                         | ({DATA_W{rd_lo}}      & long_address_low_byte)
                         | ({DATA_W{rd_consist}} & consist_address_dir)
                         | ({DATA_W{rd_rail}}    & asym_rail_select)
                         | ({DATA_W{rd_config}}  & decoder_config_byte);

   // Address selection
   assign sel_bus.short_addr = short_address_var;
   assign sel_bus.long_hi    = long_address_high_byte;
   assign sel_bus.long_lo    = long_address_low_byte;
   assign sel_bus.consist    = consist_address_dir;
   assign sel_bus.long_en    = decoder_config_byte[CFG_LONG_BIT];

   lacs_addr_select u_select (
      .sel (sel_bus)
   );

   // Command matching
   wire logic want_long;
   wire logic consist_mode;
   wire logic form_ok;
   wire logic addr_ok;
   wire logic next_cmd_hit;
   wire logic next_consist_hit;
   wire logic next_dir_eff;

   assign want_long        = (sel_bus.mode == LACS_MODE_LONG);
   assign consist_mode     = (sel_bus.mode == LACS_MODE_CONSIST);
   assign form_ok          = (cmd_long_form == want_long);
   assign addr_ok          = (cmd_addr == sel_bus.sel_addr);
   assign next_cmd_hit     = cmd_valid && form_ok && addr_ok;
   assign next_consist_hit = next_cmd_hit && consist_mode;
   // Direction holds between hits
   assign next_dir_eff     = next_cmd_hit ? (cmd_dir ^ sel_bus.dir_invert)
                                          : cmd_dir_eff;

   // Rail imbalance detection
   wire logic [1:0] rail_async;
   wire logic [1:0] rail_sync;
   wire logic [1:0] rail_en;
   wire logic [1:0] rail_hit;
   wire logic       next_asym;

   assign rail_async = {rail_left_asym, rail_right_asym};
   assign rail_en    = {asym_rail_select[RAIL_LEFT_BIT], asym_rail_select[RAIL_RIGHT_BIT]};

   lacs_sync #(.W(2)) u_rail_sync (
      .clk     (clk),
      .rst_n   (rst_n),
      .d_async (rail_async),
      .q_sync  (rail_sync)
   );

   // Each rail counts only when its select bit is set
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_rail
         assign rail_hit[gi] = rail_en[gi] & rail_sync[gi];
      end
   endgenerate

   // Value 0 masks both rails off
   assign next_asym = |rail_hit;

   // Read data, zero outside the reply cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= '0;
      end
      else
      begin
         reg_rdata <= next_reg_rdata;
      end
   end

   // Command hit pulse
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_hit <= 1'b0;
      end
      else
      begin
         cmd_hit <= next_cmd_hit;
      end
   end

   // Effective direction of the last hit
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_dir_eff <= 1'b0;
      end
      else
      begin
         cmd_dir_eff <= next_dir_eff;
      end
   end

   // Hit taken through the consist address
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hit_on_consist <= 1'b0;
      end
      else
      begin
         hit_on_consist <= next_consist_hit;
      end
   end

   // Long mode in force
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         long_active <= 1'b0;
      end
      else
      begin
         long_active <= want_long;
      end
   end

   // Address currently answered to
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active_addr <= '0;
      end
      else
      begin
         active_addr <= sel_bus.sel_addr;
      end
   end

   // Enabled rail imbalance
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         asym_trigger <= 1'b0;
      end
      else
      begin
         asym_trigger <= next_asym;
      end
   end
endmodule
`default_nettype wire

//--- tb/lacs_top_sva.sv
// Purpose: Port-level checks for the address and consist select block.
// Assumes: One clock, registered outputs, strobes one cycle long.
// Notes:   Bound to lacs_top after the module.
`timescale 1ns/1ps
`default_nettype none
module lacs_top_sva (
   // Clock and reset
   input wire logic                        clk,
   input wire logic                        rst_n,
   // Register port
   input wire logic [lacs_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [lacs_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                        reg_wr,
   input wire logic                        reg_rd,
   input wire logic [lacs_pkg::DATA_W-1:0] reg_rdata,
   // Commands and rails
   input wire logic                        cmd_valid,
   input wire logic                        cmd_long_form,
   input wire logic [lacs_pkg::EXT_W-1:0]  cmd_addr,
   input wire logic                        cmd_dir,
   input wire logic                        rail_right_asym,
   input wire logic                        rail_left_asym,
   // Results
   input wire logic                        cmd_hit,
   input wire logic                        cmd_dir_eff,
   input wire logic                        hit_on_consist,
   input wire logic                        long_active,
   input wire logic [lacs_pkg::EXT_W-1:0]  active_addr,
   input wire logic                        asym_trigger
);
   import lacs_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence cmd_taken_s;
      cmd_valid ##1 cmd_hit;
   endsequence
   rd_only_reply_a: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
      else $error("read data outside reply cycle");
   hit_cause_a: assert property (cmd_hit |-> $past(cmd_valid))
      else $error("hit without command");
   consist_hit_a: assert property (hit_on_consist |-> cmd_hit && !long_active)
      else $error("consist hit inconsistent");
   plain_dir_a: assert property (cmd_hit && !hit_on_consist |-> cmd_dir_eff == $past(cmd_dir))
      else $error("direction changed outside consist");
   hit_form_a: assert property (cmd_taken_s |-> long_active == $past(cmd_long_form)
      && active_addr == $past(cmd_addr))
      else $error("hit on wrong address or form");
   trig_cause_a: assert property (asym_trigger |->
      $past(rail_right_asym, 3) || $past(rail_left_asym, 3))
      else $error("trigger without rail imbalance");
   addr_change_a: assert property ($past(rst_n, 2) && ($changed(active_addr)
      || $changed(long_active)) |-> $past(reg_wr, 2))
      else $error("address changed without write");
   addr_range_a: assert property (active_addr <= (long_active ? 14'h27ff : 14'h007f))
      else $error("active address out of range");
endmodule
bind lacs_top lacs_top_sva u_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .cmd_valid(cmd_valid), .cmd_long_form(cmd_long_form), .cmd_addr(cmd_addr),
   .cmd_dir(cmd_dir), .rail_right_asym(rail_right_asym), .rail_left_asym(rail_left_asym),
   .cmd_hit(cmd_hit), .cmd_dir_eff(cmd_dir_eff), .hit_on_consist(hit_on_consist),
   .long_active(long_active), .active_addr(active_addr), .asym_trigger(asym_trigger));
`default_nettype wire

//--- tb/lacs_station.sv
// Purpose: Command station model: programs variables, sends commands, sets rails.
// Assumes: Signals change by non-blocking assignment just after a rising edge.
// Notes:   Long address setup also sets the long-enable bit.
`timescale 1ns/1ps
`default_nettype none
module lacs_station (
   // Clock
   input  wire logic                        clk,
   // Register port
   output logic      [lacs_pkg::ADDR_W-1:0] reg_addr,
   output logic      [lacs_pkg::DATA_W-1:0] reg_wdata,
   output logic                             reg_wr,
   output logic                             reg_rd,
   // Track side
   output logic                             cmd_valid,
   output logic                             cmd_long_form,
   output logic      [lacs_pkg::EXT_W-1:0]  cmd_addr,
   output logic                             cmd_dir,
   output logic                             rail_right_asym,
   output logic                             rail_left_asym
);
   import lacs_pkg::*;
   initial
   begin
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {cmd_valid, cmd_long_form, cmd_addr, cmd_dir} = '0;
      {rail_right_asym, rail_left_asym} = 2'b00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
   endtask
   task automatic cmd(input logic lf, input logic [13:0] a, input logic d);
      @(posedge clk);
      cmd_valid     <= 1'b1;
      cmd_long_form <= lf;
      cmd_addr      <= a;
      cmd_dir       <= d;
      @(posedge clk);
      cmd_valid     <= 1'b0;
   endtask
   task automatic set_long(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] cfg);
      wr(OFS_LONG_HI, hi);
      wr(OFS_LONG_LO, lo);
      wr(OFS_CONFIG, cfg | 8'h20);
   endtask
   task automatic rails(input logic r, input logic l);
      @(posedge clk);
      rail_right_asym <= r;
      rail_left_asym  <= l;
   endtask
endmodule
`default_nettype wire

//--- tb/loco_address_consist_select_tb.sv
// Purpose: Self-checking bench for the address and consist select block.
// Assumes: 100 MHz clock, reset held 16 cycles.
// Notes:   Read and command results checked from queued notes.
`timescale 1ns/1ps
`default_nettype none
module loco_address_consist_select_tb;
   import lacs_pkg::*;
   logic clk, rst_n, reg_wr, reg_rd, cmd_valid, cmd_long_form, cmd_dir, rr, rl, d;
   logic cmd_hit, cmd_dir_eff, hit_on_consist, long_active, asym_trigger, rd_seen, cmd_seen;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
   logic [13:0] cmd_addr, active_addr;
   logic [7:0]  rd_q[$];
   logic [2:0]  cmd_q[$];
   logic [2:0]  e;
   logic [1:0]  p;
   int          bad_count = 0, n_checks = 0, seed = 32'h47c0d9b5;
   logic [7:0]  ofs[7] = '{OFS_SHORT, 8'h11, 8'h12, 8'h13, 8'h1b, OFS_CONFIG, 8'h05};
   logic [7:0]  rv[7]  = '{RST_SHORT, 8'hc0, 8'h64, 8'h00, RST_RAIL, RST_CONFIG, 8'h00};
   logic [7:0]  cons[4] = '{8'h86, 8'h80, 8'h06, 8'h00};
   lacs_station st (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .cmd_valid(cmd_valid), .cmd_long_form(cmd_long_form),
      .cmd_addr(cmd_addr), .cmd_dir(cmd_dir), .rail_right_asym(rr), .rail_left_asym(rl));
   lacs_top DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
      .cmd_long_form(cmd_long_form), .cmd_addr(cmd_addr), .cmd_dir(cmd_dir),
      .rail_right_asym(rr), .rail_left_asym(rl), .cmd_hit(cmd_hit), .cmd_dir_eff(cmd_dir_eff),
      .hit_on_consist(hit_on_consist), .long_active(long_active), .active_addr(active_addr),
      .asym_trigger(asym_trigger));
   task automatic chk_rd(input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] reg_rdata expected %h seen %h", exp, got);
      end
   endtask
   task automatic chk_cmd(input string nm, input logic exp, input logic got);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic chk_lvl(input string nm, input logic [13:0] exp, input logic [13:0] got);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] x);
      rd_q.push_back(x);
      st.rd(a);
   endtask
   task automatic cmd_exp(input logic lf, input logic [13:0] a, input logic [2:0] x);
      cmd_q.push_back(x);
      st.cmd(lf, a, d);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      rd_seen  <= reg_rd;
      cmd_seen <= cmd_valid;
   end
   always @(negedge clk)
   begin
      if (rd_seen === 1'b1) chk_rd(rd_q.pop_front(), reg_rdata);
      if (cmd_seen === 1'b1)
      begin
         e = cmd_q.pop_front();
         chk_cmd("cmd_hit", e[2], cmd_hit);
         chk_cmd("hit_on_consist", e[1], hit_on_consist);
         if (e[2]) chk_cmd("cmd_dir_eff", e[0], cmd_dir_eff);
      end
   end
   initial
   begin
      #200000 bad_count++;
      print_verdict();
   end
   initial
   begin
      rst_n = 1'b0;
      d = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ofs[i]) rd_exp(ofs[i], rv[i]);
      d = 1'($random(seed));
      cmd_exp(1'b0, 14'h0003, {2'b10, d});
      cmd_exp(1'b1, 14'h0064, 3'b000);
      #1 chk_lvl("active_addr", 14'h0003, active_addr);
      chk_lvl("long_active", 14'h0000, long_active);
      st.wr(OFS_SHORT, 8'h80);
      st.wr(OFS_SHORT, 8'h00);
      rd_exp(OFS_SHORT, RST_SHORT);
      $display("test defaults done");
      st.wr(OFS_LONG_HI, 8'he8);
      st.wr(OFS_LONG_HI, 8'hbf);
      st.wr(OFS_LONG_LO, 8'h00);
      rd_exp(OFS_LONG_HI, 8'hc0);
      rd_exp(OFS_LONG_LO, 8'h64);
      st.set_long(8'he7, 8'hff, RST_CONFIG);
      rd_exp(OFS_LONG_HI, 8'he7);
      cmd_exp(1'b1, 14'h27ff, {2'b10, d});
      cmd_exp(1'b0, 14'h0003, 3'b000);
      #1 chk_lvl("active_addr", 14'h27ff, active_addr);
      chk_lvl("long_active", 14'h0001, long_active);
      $display("test long address done");
      foreach (cons[i])
      begin
         v = cons[i];
         d = 1'($random(seed));
         st.wr(OFS_CONSIST, v);
         rd_exp(OFS_CONSIST, v);
         cmd_exp(1'b0, 14'h0006, {{2{v[6:0] == 7'h06}}, d ^ v[7]});
         cmd_exp(1'b1, 14'h27ff, {v[6:0] == 7'h00, 1'b0, d});
      end
      $display("test consist done");
      for (int s = 0; s < 4; s++)
      begin
         st.wr(OFS_RAIL, 8'(s));
         repeat (4)
         begin
            p = 2'($random(seed));
            st.rails(p[0], p[1]);
            repeat (4) @(posedge clk);
            v = 8'((s[0] & p[0]) | (s[1] & p[1]));
            #1 chk_lvl("asym_trigger", v, asym_trigger);
         end
      end
      $display("test rail select done");
      repeat (3) @(posedge clk);
      chk_lvl("pending notes", 14'h0000, 14'(rd_q.size() + cmd_q.size()));
      print_verdict();
   end
endmodule
`default_nettype wire
